//--- inc/xfer_pkg.sv
// Shared constants and types for the interrupt transfer descriptor engine
package xfer_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_DESC_W0  = 8'h00;
    localparam logic [7:0] OFS_DESC_W1  = 8'h04;
    localparam logic [7:0] OFS_DESC_W2  = 8'h08;
    localparam logic [7:0] OFS_DESC_W3  = 8'h0C;
    localparam logic [7:0] OFS_DESC_W4  = 8'h10;
    localparam logic [7:0] OFS_FRAME    = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;

    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // Descriptor word 0
    localparam int VALID_BIT  = 0;
    localparam int TOTAL_LSB  = 3;
    localparam int TOTAL_W    = 15;
    localparam int MAXPKT_LSB = 18;
    localparam int MAXPKT_W   = 11;
    localparam int MULT_LSB   = 29;
    localparam int MULT_W     = 2;
    // Descriptor word 1
    localparam int TOKEN_LSB    = 10;
    localparam int SPLIT_BIT    = 14;
    localparam int HUB_PORT_LSB = 18;
    localparam int HUB_DEV_LSB  = 25;
    localparam int HUB_W        = 7;
    localparam logic [1:0] TOKEN_IN = 2'b01;
    // Descriptor word 2 and word 4
    localparam int FSEL_LSB = 3;
    localparam int FSEL_W   = 5;
    localparam int MASK_LSB = 0;
    localparam int MASK_W   = 8;
    // Descriptor word 3
    localparam int DONE_LSB   = 0;
    localparam int TOGGLE_BIT = 25;

    // Frame timing
    localparam int UFRAME_W = 3;
    localparam int FRAME_W  = 11;

    // Interrupt status bits
    localparam int IRQ_W     = 2;
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_FATAL = 1;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT  = 2'b10
    } exec_state_t;
endpackage

//--- inc/sched_if.sv
// Carrier between the descriptor engine and its polling-slot matcher
`timescale 1ns/1ps
interface sched_if;
    import xfer_pkg::*;
    logic [FSEL_W-1:0]   frame_low;
    logic [UFRAME_W-1:0] uframe;
    logic [FSEL_W-1:0]   frame_sel;
    logic [MASK_W-1:0]   act_mask;
    logic                hit;
    modport engine (output frame_low, output uframe, output frame_sel, output act_mask, input hit);
    modport matcher (input frame_low, input uframe, input frame_sel, input act_mask, output hit);
endinterface

//--- src/poll_match.sv
// Decides whether the current microframe is a polling slot for the descriptor
`timescale 1ns/1ps
module poll_match
    import xfer_pkg::*;
(
    sched_if.matcher sif
);
    // Ones from the top set bit of the frame selector downward
    function automatic logic [FSEL_W-1:0] fill_down(input logic [FSEL_W-1:0] v);
        logic [FSEL_W-1:0] r;
        r = v;
        for (int i = 1; i < FSEL_W; i++) begin
            r = r | (r >> i);
        end
        return r;
    endfunction

    wire [FSEL_W-1:0] phase_bits = fill_down(sif.frame_sel);
    wire              uf_active  = sif.act_mask[sif.uframe];
    wire              sub_ms     = (sif.frame_sel == '0);
    // Period is twice the top selector bit; the frame number modulo that period must equal the selector
    wire              frame_ok   = (((sif.frame_low ^ sif.frame_sel) & phase_bits) == '0);

    assign sif.hit = uf_active && (sub_ms || frame_ok);
endmodule

//--- src/intr_desc_exec.sv
// Executes one periodic interrupt transfer descriptor toward a downstream endpoint
// Overview of operation
// - Multiplier field gives how many packets may go out per execution.
// - Each packet is limited to the maximum packet size field.
// - Total length field is the full byte count moved, up to 32767.
// - Hardware clears valid on completion or on a fatal error.
// - Zero frame select: poll in each microframe whose activity bit is set.
// - Split descriptors carry seven-bit hub number and hub port.
// - Software writes the current toggle; hardware writes back the next one.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module intr_desc_exec
    import xfer_pkg::*;
#(
    parameter int MAXPKT_BITS = MAXPKT_W,
    parameter int TOTAL_BITS  = TOTAL_W
) (
    input  wire logic              CLK_I,
    input  wire logic              RST_N_I,
    input  wire logic [ADDR_W-1:0] REG_ADDR_I,
    input  wire logic [DATA_W-1:0] REG_WDATA_I,
    input  wire logic              REG_WR_I,
    input  wire logic              REG_RD_I,
    output logic      [DATA_W-1:0] REG_RDATA_O,
    input  wire logic              MFRAME_TICK_I,
    output logic                   PKT_REQ_O,
    output logic [MAXPKT_BITS-1:0] PKT_BYTES_O,
    output logic                   PKT_IN_O,
    output logic                   PKT_TOGGLE_O,
    output logic                   PKT_SPLIT_O,
    output logic       [HUB_W-1:0] HUB_DEV_O,
    output logic       [HUB_W-1:0] HUB_PORT_O,
    input  wire logic              PKT_DONE_I,
    input  wire logic [MAXPKT_BITS-1:0] PKT_COUNT_I,
    input  wire logic              PKT_FATAL_I,
    output logic                   IRQ_O
);
    function automatic logic [TOTAL_BITS-1:0] min_len(input logic [TOTAL_BITS-1:0] a,
                                                      input logic [TOTAL_BITS-1:0] b);
        return (a < b) ? a : b;
    endfunction

    // Register state
    logic [DATA_W-1:0]   w0;
    logic [DATA_W-1:0]   w1;
    logic [DATA_W-1:0]   w2;
    logic [DATA_W-1:0]   w4;
    logic [TOTAL_BITS-1:0] bytes_done_count;
    logic                toggle_bit;
    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_mask;
    logic [UFRAME_W-1:0] uframe;
    logic [FRAME_W-1:0]  frame_num;
    logic                tick_d;

    // Execution state
    exec_state_t         state;
    exec_state_t         next_state;
    logic [MULT_W-1:0]   pkts_left;
    logic [MULT_W-1:0]   next_pkts_left;
    logic [MAXPKT_BITS-1:0] pkt_bytes;

    sched_if sif ();

    poll_match u_match (
        .sif (sif)
    );

    // Field views of the descriptor
    wire                    desc_valid          = w0[VALID_BIT];
    wire [TOTAL_BITS-1:0]   total_bytes_to_move = w0[TOTAL_LSB +: TOTAL_BITS];
    wire [MAXPKT_BITS-1:0]  max_packet_bytes    = w0[MAXPKT_LSB +: MAXPKT_BITS];
    wire [MULT_W-1:0]       mult                = w0[MULT_LSB +: MULT_W];
    wire [TOTAL_BITS-1:0]   max_pkt_ext         = TOTAL_BITS'(max_packet_bytes);
    wire [TOTAL_BITS-1:0]   remaining           = total_bytes_to_move - bytes_done_count;

    assign sif.frame_low = frame_num[FSEL_W-1:0];
    assign sif.uframe    = uframe;
    assign sif.frame_sel = w2[FSEL_LSB +: FSEL_W];
    assign sif.act_mask  = w4[MASK_LSB +: MASK_W];

    // Register decode
    wire wr_w0   = REG_WR_I && (REG_ADDR_I == OFS_DESC_W0);
    wire wr_w1   = REG_WR_I && (REG_ADDR_I == OFS_DESC_W1);
    wire wr_w2   = REG_WR_I && (REG_ADDR_I == OFS_DESC_W2);
    wire wr_w3   = REG_WR_I && (REG_ADDR_I == OFS_DESC_W3);
    wire wr_w4   = REG_WR_I && (REG_ADDR_I == OFS_DESC_W4);
    wire wr_stat = REG_WR_I && (REG_ADDR_I == OFS_IRQ_STAT);
    wire wr_mask = REG_WR_I && (REG_ADDR_I == OFS_IRQ_MASK);

    // Packet completion bookkeeping
    wire [TOTAL_BITS-1:0] got_bytes  = min_len(TOTAL_BITS'(PKT_COUNT_I), TOTAL_BITS'(pkt_bytes));
    wire [TOTAL_BITS-1:0] done_sum   = bytes_done_count + got_bytes;
    wire                  short_pkt  = got_bytes < TOTAL_BITS'(pkt_bytes);
    wire                  reached    = done_sum >= total_bytes_to_move;
    wire                  pkt_ok     = (state == ST_WAIT) && PKT_DONE_I && !PKT_FATAL_I;
    wire                  pkt_fatal  = (state == ST_WAIT) && PKT_FATAL_I;
    wire                  empty_job  = (state == ST_ISSUE) && (remaining == '0);
    wire                  finished   = (pkt_ok && (short_pkt || reached)) || empty_job;
    wire                  clear_valid = finished || pkt_fatal;
    wire                  slot_start = tick_d && desc_valid && sif.hit && (mult != '0);

    wire [IRQ_W-1:0] irq_event = {pkt_fatal, finished};

    always_comb begin
        next_state     = state;
        next_pkts_left = pkts_left;
        case (state)
            ST_IDLE: begin
                if (slot_start) begin
                    next_pkts_left = mult;
                    next_state     = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (empty_job) begin
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (pkt_fatal || finished) begin
                    next_state = ST_IDLE;
                end else if (pkt_ok) begin
                    next_pkts_left = pkts_left - MULT_W'(1);
                    // Spent packets wait for the next polling slot
                    next_state = (pkts_left == MULT_W'(1)) ? ST_IDLE : ST_ISSUE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state     <= ST_IDLE;
            pkts_left <= '0;
            pkt_bytes <= '0;
        end else begin
            state     <= next_state;
            pkts_left <= next_pkts_left;
            if (state != ST_ISSUE && next_state == ST_ISSUE || state == ST_WAIT && next_state == ST_ISSUE) begin
                // Length of the coming packet, computed from the current progress
                pkt_bytes <= MAXPKT_BITS'(min_len(max_pkt_ext, pkt_ok ? total_bytes_to_move - done_sum
                                                                      : remaining));
            end
        end
    end

    // Microframe counter advances on each microframe start; frame counter on the start that wraps the microframe count
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            uframe    <= '0;
            frame_num <= '0;
            tick_d    <= 1'b0;
        end else begin
            tick_d <= MFRAME_TICK_I;
            if (MFRAME_TICK_I) begin
                uframe <= uframe + UFRAME_W'(1);
                if (uframe == '1) begin
                    frame_num <= frame_num + FRAME_W'(1);
                end
            end
        end
    end

    // Descriptor words; a software write beats a hardware clear in the same cycle
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            w0 <= WORD_RESET;
            w1 <= WORD_RESET;
            w2 <= WORD_RESET;
            w4 <= WORD_RESET;
        end else begin
            if (wr_w0) begin
                w0 <= REG_WDATA_I;
            end else if (clear_valid) begin
                w0[VALID_BIT] <= 1'b0;
            end
            if (wr_w1) begin
                w1 <= REG_WDATA_I;
            end
            if (wr_w2) begin
                w2 <= REG_WDATA_I;
            end
            if (wr_w4) begin
                w4 <= REG_WDATA_I;
            end
        end
    end

    // Progress and toggle; hardware update wins over a software load
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            bytes_done_count <= '0;
            toggle_bit       <= 1'b0;
        end else if (pkt_ok) begin
            bytes_done_count <= done_sum;
            toggle_bit       <= ~toggle_bit;
        end else if (wr_w3) begin
            bytes_done_count <= REG_WDATA_I[DONE_LSB +: TOTAL_BITS];
            toggle_bit       <= REG_WDATA_I[TOGGLE_BIT];
        end
    end

    // Sticky events: set wins over a write-one clear
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            irq_stat <= (irq_stat & ~(wr_stat ? REG_WDATA_I[IRQ_W-1:0] : '0)) | irq_event;
            if (wr_mask) begin
                irq_mask <= REG_WDATA_I[IRQ_W-1:0];
            end
        end
    end

    // Read mux; unmapped offsets read zero
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        case (REG_ADDR_I)
            OFS_DESC_W0:  rd_mux = w0;
            OFS_DESC_W1:  rd_mux = w1;
            OFS_DESC_W2:  rd_mux = w2;
            OFS_DESC_W3:  rd_mux = (DATA_W'(toggle_bit) << TOGGLE_BIT) | DATA_W'(bytes_done_count);
            OFS_DESC_W4:  rd_mux = w4;
            OFS_FRAME:    rd_mux = DATA_W'({frame_num, uframe});
            OFS_IRQ_STAT: rd_mux = DATA_W'(irq_stat);
            OFS_IRQ_MASK: rd_mux = DATA_W'(irq_mask);
            default:      rd_mux = '0;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            REG_RDATA_O <= '0;
        end else begin
            REG_RDATA_O <= REG_RD_I ? rd_mux : '0;
        end
    end

    assign PKT_REQ_O    = (state == ST_WAIT);
    assign PKT_BYTES_O  = pkt_bytes;
    assign PKT_IN_O     = (w1[TOKEN_LSB +: $bits(TOKEN_IN)] == TOKEN_IN);
    assign PKT_TOGGLE_O = toggle_bit;
    assign PKT_SPLIT_O  = w1[SPLIT_BIT];
    assign HUB_DEV_O    = w1[HUB_DEV_LSB +: HUB_W];
    assign HUB_PORT_O   = w1[HUB_PORT_LSB +: HUB_W];
    assign IRQ_O        = |(irq_stat & irq_mask);
endmodule

//--- bench/usb_endpoint_model.sv
// Behavioural downstream endpoint that answers packet requests
`timescale 1ns/1ps
module usb_endpoint_model
    import xfer_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                req_i,
    input  wire logic [MAXPKT_W-1:0] bytes_i,
    input  wire logic [2:0]          delay_i,
    input  wire logic                short_i,
    input  wire logic                fail_i,
    output logic                     done_o,
    output logic      [MAXPKT_W-1:0] count_o,
    output logic                     fatal_o
);
    logic [2:0] wait_cnt;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_cnt <= 3'h0;
            done_o   <= 1'b0;
            fatal_o  <= 1'b0;
            count_o  <= '0;
        end else begin
            done_o   <= 1'b0;
            fatal_o  <= 1'b0;
            // Junk outside an answer, so a stale count can never pass
            count_o  <= ~count_o;
            wait_cnt <= 3'h0;
            if (req_i && !done_o && !fatal_o) begin
                wait_cnt <= wait_cnt + 3'h1;
                if (wait_cnt == delay_i) begin
                    wait_cnt <= 3'h0;
                    fatal_o  <= fail_i;
                    done_o   <= !fail_i;
                    count_o  <= short_i ? bytes_i - 1'b1 : bytes_i;
                end
            end
        end
    end
endmodule

//--- bench/intr_desc_exec_assertions.sv
// Port-level checks for the descriptor engine
`timescale 1ns/1ps
module intr_desc_exec_assertions
    import xfer_pkg::*;
#(
    parameter int MAXPKT_BITS = MAXPKT_W
) (
    input wire logic                   CLK_I,
    input wire logic                   RST_N_I,
    input wire logic                   REG_RD_I,
    input wire logic [DATA_W-1:0]      REG_RDATA_O,
    input wire logic                   MFRAME_TICK_I,
    input wire logic                   PKT_REQ_O,
    input wire logic [MAXPKT_BITS-1:0] PKT_BYTES_O,
    input wire logic                   PKT_TOGGLE_O,
    input wire logic                   PKT_SPLIT_O,
    input wire logic [HUB_W-1:0]       HUB_DEV_O,
    input wire logic [HUB_W-1:0]       HUB_PORT_O,
    input wire logic                   PKT_DONE_I,
    input wire logic [MAXPKT_BITS-1:0] PKT_COUNT_I,
    input wire logic                   PKT_FATAL_I
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence good_pkt;
        PKT_REQ_O && PKT_DONE_I && !PKT_FATAL_I;
    endsequence
    sequence short_pkt;
        good_pkt ##0 (PKT_COUNT_I < PKT_BYTES_O);
    endsequence
    a_rdata_quiet: assert property (!REG_RD_I |=> REG_RDATA_O == '0) else $error("read data outside read");
    a_req_cause: assert property ($rose(PKT_REQ_O) |-> $past(MFRAME_TICK_I, 3) || $past(PKT_DONE_I, 2))
        else $error("request without slot or follow-on");
    a_req_holds: assert property (PKT_REQ_O && !PKT_DONE_I && !PKT_FATAL_I
        |=> PKT_REQ_O && $stable(PKT_BYTES_O)) else $error("request or size moved early");
    a_req_drops: assert property (PKT_REQ_O && (PKT_DONE_I || PKT_FATAL_I) |=> !PKT_REQ_O)
        else $error("request kept after answer");
    a_fatal_stops: assert property (PKT_REQ_O && PKT_FATAL_I |=> !PKT_REQ_O [*8]) else $error("run after fatal");
    a_short_ends: assert property (short_pkt |=> !PKT_REQ_O [*4]) else $error("run after short packet");
    a_toggle_flip: assert property ($rose(PKT_REQ_O) && $past(PKT_REQ_O, 2) && $past(PKT_DONE_I, 2)
        && !$past(PKT_FATAL_I, 2) |-> PKT_TOGGLE_O != $past(PKT_TOGGLE_O, 2)) else $error("toggle not flipped");
    a_hub_stable: assert property (PKT_REQ_O && $past(PKT_REQ_O)
        |-> $stable({HUB_DEV_O, HUB_PORT_O, PKT_SPLIT_O})) else $error("hub fields moved");
endmodule
bind intr_desc_exec intr_desc_exec_assertions #(.MAXPKT_BITS(MAXPKT_BITS)) intr_desc_exec_assertions_inst (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .MFRAME_TICK_I(MFRAME_TICK_I),
    .PKT_REQ_O(PKT_REQ_O), .PKT_BYTES_O(PKT_BYTES_O), .PKT_TOGGLE_O(PKT_TOGGLE_O), .PKT_SPLIT_O(PKT_SPLIT_O),
    .HUB_DEV_O(HUB_DEV_O), .HUB_PORT_O(HUB_PORT_O), .PKT_DONE_I(PKT_DONE_I), .PKT_COUNT_I(PKT_COUNT_I),
    .PKT_FATAL_I(PKT_FATAL_I));

//--- bench/tb.sv
// Self-checking bench: descriptor setup, polling slots, packets and interrupts
`timescale 1ns/1ps
module tb;
    import xfer_pkg::*;
    logic                clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b0, fail = 1'b0, short_pkt = 1'b0;
    logic [2:0]          delay = 3'h0;
    logic [ADDR_W-1:0]   addr = 8'h00;
    logic [DATA_W-1:0]   wdata = 32'h0000_0000, rdata, lfsr = 32'h0000_6c92;
    logic                req, pin, tog, split, done, fatal, irq;
    logic [MAXPKT_W-1:0] pbytes, pcount;
    logic [HUB_W-1:0]    hdev, hport;
    int                  n_errors = 0, n_compared = 0, pos = 0, got = 0;
    always #5 clk = ~clk;
    always @(posedge req) got++;
    intr_desc_exec intr_desc_exec_inst (.CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
        .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .MFRAME_TICK_I(tick), .PKT_REQ_O(req),
        .PKT_BYTES_O(pbytes), .PKT_IN_O(pin), .PKT_TOGGLE_O(tog), .PKT_SPLIT_O(split), .HUB_DEV_O(hdev),
        .HUB_PORT_O(hport), .PKT_DONE_I(done), .PKT_COUNT_I(pcount), .PKT_FATAL_I(fatal), .IRQ_O(irq));
    usb_endpoint_model usb_endpoint_model_inst (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .bytes_i(pbytes),
        .delay_i(delay), .short_i(short_pkt), .fail_i(fail), .done_o(done), .count_o(pcount), .fatal_o(fatal));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int period(input int f);
        int p = 2;
        while (p <= f) p = p * 2;
        return p;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // One idle edge so a following call never reassigns the strobe in the same step
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        // Read data stand in this cycle and are taken at the edge that closes it
        @(posedge clk);
        chk(what, exp, rdata);
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Writes a descriptor, steps microframes and follows every packet against the model
    task automatic run(input int mult, input int maxp, input int total, input int fsel, input int mask,
                       input int n_ticks, input logic is_in);
        int bdone = 0, want, w, n, stat = 0;
        logic valid = 1'b1, t = 1'b0;
        logic [31:0] w0, w1;
        lfsr = nxt(lfsr);
        w1 = {lfsr[13:0], 3'h0, lfsr[20], 2'h0, is_in ? TOKEN_IN : 2'h0, 10'h000};
        w0 = {1'h0, mult[1:0], maxp[10:0], total[14:0], 2'h0, 1'h1};
        wr_reg(OFS_IRQ_STAT, 32'h0000_0003);
        wr_reg(OFS_DESC_W1, w1);
        wr_reg(OFS_DESC_W2, fsel << 3);
        wr_reg(OFS_DESC_W3, 32'h0000_0000);
        wr_reg(OFS_DESC_W4, mask);
        wr_reg(OFS_DESC_W0, w0);
        for (int k = 0; k < n_ticks; k++) begin
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            pos++;
            n = got;
            if (valid && mult > 0 && mask[pos % 8] && (fsel == 0 || (pos / 8) % period(fsel) == fsel))
                for (int j = 0; j < mult && valid; j++) begin
                    if (bdone >= total) begin
                        // Nothing left to move: completes without a packet
                        valid = 1'b0;
                        stat = 1;
                        break;
                    end
                    want = (maxp < total - bdone) ? maxp : total - bdone;
                    n++;
                    w = 0;
                    while (req !== 1'b1 && w < 20) begin
                        @(posedge clk);
                        #1;
                        w++;
                    end
                    chk("packet bytes", want, pbytes);
                    chk("toggle", t, tog);
                    chk("token and hub", {is_in, w1[14], w1[31:18]}, {pin, split, hdev, hport});
                    while (done !== 1'b1 && fatal !== 1'b1 && w < 40) begin
                        @(posedge clk);
                        #1;
                        w++;
                    end
                    bdone += fail ? 0 : short_pkt ? want - 1 : want;
                    t ^= !fail;
                    if (fail || short_pkt || bdone >= total) begin
                        valid = 1'b0;
                        stat = fail ? 2 : 1;
                    end
                    @(posedge clk);
                    #1;
                end
            repeat (8) @(posedge clk);
            chk("packet count", n, got);
        end
        rd_reg(OFS_DESC_W0, {w0[31:1], valid}, "valid bit");
        rd_reg(OFS_DESC_W3, {6'h00, t, 10'h000, bdone[14:0]}, "bytes done");
        rd_reg(OFS_IRQ_STAT, stat, "irq status");
        chk("irq line", stat != 0, irq);
    endtask
    initial begin
        #200_000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_reg(OFS_DESC_W0, WORD_RESET, "reset word");
        rd_reg(8'h40, 32'h0000_0000, "unmapped");
        wr_reg(OFS_IRQ_MASK, 32'h0000_0003);
        run(3, 8, 20, 0, 8'hFF, 2, 1'b1);
        delay <= 3'h6;
        run(1, 16, 40, 0, 8'h55, 8, 1'b0);
        short_pkt <= 1'b1;
        lfsr = nxt(lfsr);
        run(2, 64 + lfsr[4:0], 1000, 0, 8'hFF, 1, 1'b1);
        short_pkt <= 1'b0;
        delay <= 3'h0;
        run(1, 4, 12, 1, 8'h04, 32, 1'b0);
        fail <= 1'b1;
        run(2, 8, 64, 0, 8'hFF, 1, 1'b1);
        fail <= 1'b0;
        run(0, 8, 64, 0, 8'hFF, 2, 1'b1);
        run(1, 8, 0, 0, 8'hFF, 1, 1'b1);
        run(3, 2047, 32767, 0, 8'hFF, 1, 1'b0);
        rd_reg(OFS_FRAME, pos, "frame position");
        tally_and_finish();
    end
endmodule
